// ### design/bmsq_stats_queue.sv
`timescale 1ns/1ps
`include "bmsq_defs.svh"

// Functional notes
// - Channel starts only after driver posts its first buffer, empty or not, and notifies.
// - A request marks the held buffer used and pulses a used notification.
// - On a posted buffer the device consumes entries and keeps the buffer held.
// - Each entry is a 16-bit tag then a 64-bit value; ten bytes taken.
// - Entries with unrecognised tags are skipped without error.
// - Entries are accepted in any tag order.
// - Legacy mode uses guest native byte order, otherwise little-endian.
// - In legacy mode the first buffer after initialization is ignored.
// - Tags 0 to 4: swap in, swap out, major, minor faults, unused bytes.
// - Tags 5 to 9: total, available, cache, huge alloc ok, huge failed.
// - Everything applies only while the statistics-queue feature is negotiated.
// - The statistics queue is queue index 2, present only with the feature.
module bmsq_stats_queue (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic statsQueueFeature,
	input wire logic driverReady,
	input wire logic legacyMode,
	input wire logic guestBigEndian,
	input wire logic statsRequest,
	input wire logic availNotify,
	input wire bmsq_pkg::bmsq_tag_t availQueue,
	input wire bmsq_pkg::bmsq_cnt_t availEntries,
	input wire logic entryValid,
	output logic entryReady,
	input wire bmsq_pkg::bmsq_entry_t entryData,
	output logic usedNotify,
	output logic statValid,
	input wire logic statReady,
	output bmsq_pkg::bmsq_tag_t statTag,
	output bmsq_pkg::bmsq_val_t statValue,
	output logic channelActive,
	output logic bufferHeld,
	output logic requestPending,
	output bmsq_pkg::bmsq_tag_t skippedCount
);
	import bmsq_pkg::*;

	// ----------------------------------------
	// State and decode.
	// ----------------------------------------
	bmsq_state_t state_q;
	bmsq_state_t state_d;
	bmsq_cnt_t remain_q;
	bmsq_cnt_t remain_d;
	logic reqPend_q;
	logic discard_q;
	logic discard_d;
	logic usedNotify_q;
	bmsq_tag_t skipped_q;
	bmsq_entry_t swapped;
	bmsq_tag_t decTag;
	bmsq_val_t decValue;
	logic bufInReady;
	logic bufOutValid;
	logic [`BMSQ_ENTRY_W-1:0] bufOut;

	wire inIdle = (state_q == BMSQ_IDLE);
	wire inHeld = (state_q == BMSQ_HELD);
	wire inWait = (state_q == BMSQ_WAIT);
	wire inConsume = (state_q == BMSQ_CONSUME);
	wire onStatsQueue = (availQueue == `BMSQ_QUEUE_INDEX);
	wire posted = availNotify && onStatsQueue && statsQueueFeature;
	wire postedEmpty = posted && (availEntries == `BMSQ_CNT_ZERO);
	wire nativeSwap = legacyMode && guestBigEndian;

	always_comb begin
		swapped = '0;
		for (int b = 0; b < `BMSQ_ENTRY_BYTES; b++) begin
			swapped[8*b +: 8] = entryData[8*(`BMSQ_ENTRY_BYTES-1-b) +: 8];
		end
	end

	assign decTag = nativeSwap ? swapped[`BMSQ_ENTRY_W-1 -: `BMSQ_TAG_W]
		: entryData[`BMSQ_TAG_LSB +: `BMSQ_TAG_W];
	assign decValue = nativeSwap ? swapped[`BMSQ_VAL_W-1:0]
		: entryData[`BMSQ_VAL_LSB +: `BMSQ_VAL_W];

	wire tagLow = (decTag <= `BMSQ_TAG_UNUSED_BYTES);
	wire tagHigh = (decTag >= `BMSQ_TAG_TOTAL_BYTES) && (decTag <= `BMSQ_TAG_HUGE_ALLOC_FAILED);
	wire tagKnown = tagLow || tagHigh;
	// Every known entry outside a discarded buffer passes on regardless of order.
	wire passEntry = tagKnown && !discard_q;
	wire bufInValid = inConsume && entryValid && passEntry;
	// Unknown or discarded entries are drained without a push.
	assign entryReady = inConsume && clkEn && (bufInReady || !passEntry);
	wire entryTake = entryValid && entryReady;
	wire lastTake = entryTake && (remain_q == `BMSQ_CNT_ONE);

	// ----------------------------------------
	// Sequencing.
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		remain_d = remain_q;
		discard_d = discard_q;
		case (state_q)
			BMSQ_IDLE: begin
				// Activation on the first posted buffer.
				if (posted && driverReady) begin
					state_d = postedEmpty ? BMSQ_HELD : BMSQ_CONSUME;
					remain_d = availEntries;
					discard_d = legacyMode;
				end
			end
			BMSQ_HELD: begin
				// Use the held buffer on request.
				if (reqPend_q) begin
					state_d = BMSQ_WAIT;
				end
			end
			BMSQ_WAIT: begin
				if (posted) begin
					state_d = postedEmpty ? BMSQ_HELD : BMSQ_CONSUME;
					remain_d = availEntries;
					discard_d = 1'b0;
				end
			end
			BMSQ_CONSUME: begin
				if (entryTake) begin
					remain_d = remain_q - `BMSQ_CNT_ONE;
				end
				if (lastTake) begin
					state_d = BMSQ_HELD;
					discard_d = 1'b0;
				end
			end
			default: begin
				state_d = BMSQ_IDLE;
			end
		endcase
		// Feature gone returns the channel to idle.
		if (!statsQueueFeature) begin
			state_d = BMSQ_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q <= BMSQ_IDLE;
			remain_q <= `BMSQ_CNT_ZERO;
			discard_q <= 1'b0;
			usedNotify_q <= 1'b0;
		end else if (clkEn) begin
			state_q <= state_d;
			remain_q <= remain_d;
			discard_q <= discard_d;
			// Notification only leaves the held state.
			usedNotify_q <= inHeld && reqPend_q && statsQueueFeature;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			reqPend_q <= 1'b0;
			skipped_q <= `BMSQ_SKIP_ZERO;
		end else if (clkEn) begin
			if (statsRequest && statsQueueFeature) begin
				reqPend_q <= 1'b1;
			end else if (inHeld || !statsQueueFeature) begin
				reqPend_q <= 1'b0;
			end
			if (entryTake && !tagKnown && !discard_q) begin
				skipped_q <= skipped_q + `BMSQ_SKIP_ONE;
			end
		end
	end

	// ----------------------------------------
	// Output buffer.
	// ----------------------------------------
	bmsq_entry_buf #(
		.W(`BMSQ_ENTRY_W)
	) u_buf (
		.sys_clk(sys_clk),
		.srst(srst),
		.clkEn(clkEn),
		.inValid(bufInValid),
		.inReady(bufInReady),
		.inData({decValue, decTag}),
		.outValid(bufOutValid),
		.outReady(statReady),
		.outData(bufOut)
	);

	assign statValid = bufOutValid;
	assign statTag = bufOut[`BMSQ_TAG_LSB +: `BMSQ_TAG_W];
	assign statValue = bufOut[`BMSQ_VAL_LSB +: `BMSQ_VAL_W];
	assign usedNotify = usedNotify_q;
	assign channelActive = !inIdle;
	assign bufferHeld = inHeld || inConsume;
	assign requestPending = reqPend_q;
	assign skippedCount = skipped_q;

	// ----------------------------------------
	// Checks.
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);

	a_used_needs_hold: assert property (usedNotify |-> inWait &&
		($past(inHeld) || ($past(usedNotify) && !$past(clkEn))))
		else $error("used notification without a held buffer");
	a_request_uses: assert property (inHeld && reqPend_q && clkEn &&
		statsQueueFeature |=> usedNotify)
		else $error("pending request did not use the held buffer");
	a_feature_gate: assert property (!statsQueueFeature && clkEn |=> inIdle)
		else $error("channel active without the feature");
	a_activate_post: assert property (inIdle && posted && driverReady &&
		clkEn |=> !inIdle)
		else $error("channel did not start on first buffer");
	a_unknown_skip: assert property (inConsume && entryValid && !tagKnown
		|-> !bufInValid && (entryReady == clkEn))
		else $error("unknown tag not skipped");
	a_any_order: assert property (entryTake && tagKnown && !discard_q
		|=> statValid)
		else $error("known entry refused");
	a_hold_after: assert property (lastTake && statsQueueFeature |=> inHeld)
		else $error("buffer not held after consumption");
	a_first_ignored: assert property (discard_q |-> !bufInValid)
		else $error("first legacy buffer forwarded");
	a_le_order: assert property (entryTake && !nativeSwap |->
		decTag == entryData[`BMSQ_TAG_LSB +: `BMSQ_TAG_W])
		else $error("little-endian tag decode wrong");
	a_tag_range: assert property (statValid |-> statTag <= `BMSQ_TAG_HUGE_ALLOC_FAILED)
		else $error("unrecognised tag delivered");
	a_queue_select: assert property (inWait && !onStatsQueue &&
		statsQueueFeature && !usedNotify |=> inWait)
		else $error("buffer taken from another queue");

	c_full_cycle: cover property (usedNotify ##[1:50] lastTake);
	c_empty_first: cover property (inIdle && postedEmpty && driverReady ##1 inHeld);
	c_skip_entry: cover property (entryTake && !tagKnown);
	c_buf_stall: cover property (statValid && !statReady && !bufInReady);

endmodule // bmsq_stats_queue

// ### common/bmsq_defs.svh
`ifndef BMSQ_DEFS_SVH
`define BMSQ_DEFS_SVH

// ----------------------------------------
// Entry layout.
// ----------------------------------------
`define BMSQ_TAG_W 16
`define BMSQ_VAL_W 64
`define BMSQ_ENTRY_BYTES 10
`define BMSQ_ENTRY_W 80
`define BMSQ_TAG_LSB 0
`define BMSQ_VAL_LSB 16
`define BMSQ_CNT_W 8

// ----------------------------------------
// Queue and tag encodings.
// ----------------------------------------
`define BMSQ_QUEUE_INDEX 16'h0002
`define BMSQ_TAG_SWAP_IN 16'h0000
`define BMSQ_TAG_SWAP_OUT 16'h0001
`define BMSQ_TAG_MAJOR_FAULTS 16'h0002
`define BMSQ_TAG_MINOR_FAULTS 16'h0003
`define BMSQ_TAG_UNUSED_BYTES 16'h0004
`define BMSQ_TAG_TOTAL_BYTES 16'h0005
`define BMSQ_TAG_AVAILABLE_ESTIMATE 16'h0006
`define BMSQ_TAG_RECLAIMABLE_CACHE 16'h0007
`define BMSQ_TAG_HUGE_ALLOC_OK 16'h0008
`define BMSQ_TAG_HUGE_ALLOC_FAILED 16'h0009

// ----------------------------------------
// Reset and increment values.
// ----------------------------------------
`define BMSQ_CNT_ZERO 8'h00
`define BMSQ_CNT_ONE 8'h01
`define BMSQ_SKIP_ZERO 16'h0000
`define BMSQ_SKIP_ONE 16'h0001

`endif

// ### common/bmsq_pkg.sv
package bmsq_pkg;

	typedef logic [15:0] bmsq_tag_t;
	typedef logic [63:0] bmsq_val_t;
	typedef logic [79:0] bmsq_entry_t;
	typedef logic [7:0] bmsq_cnt_t;

	typedef enum logic [3:0] {
		BMSQ_IDLE = 4'b0001,
		BMSQ_HELD = 4'b0010,
		BMSQ_WAIT = 4'b0100,
		BMSQ_CONSUME = 4'b1000
	} bmsq_state_t;

endpackage

// ### design/bmsq_entry_buf.sv
`timescale 1ns/1ps

module bmsq_entry_buf #(
	parameter int W = 80
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic clkEn,
	input wire logic inValid,
	output logic inReady,
	input wire logic [W-1:0] inData,
	output logic outValid,
	input wire logic outReady,
	output logic [W-1:0] outData
);

	logic [W-1:0] mem_q [2];
	logic wrIdx_q;
	logic rdIdx_q;
	logic [1:0] cnt_q;
	logic [1:0] cnt_d;
	wire push = inValid && inReady && clkEn;
	wire pop = outValid && outReady && clkEn;

	assign inReady = (cnt_q != 2'h2);
	assign outValid = (cnt_q != 2'h0);
	assign outData = mem_q[rdIdx_q];
	assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wrIdx_q <= 1'b0;
			rdIdx_q <= 1'b0;
			cnt_q <= 2'h0;
		end else if (clkEn) begin
			wrIdx_q <= wrIdx_q ^ push;
			rdIdx_q <= rdIdx_q ^ pop;
			cnt_q <= cnt_d;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem_q[wrIdx_q] <= inData;
		end
	end

endmodule // bmsq_entry_buf

// ### tb/bmsq_guest_model.sv
`timescale 1ns/1ps

// --------
// Guest driver side.
// --------
module bmsq_guest_model (
	input wire logic sys_clk,
	input wire logic clkEn,
	input wire logic entryReady,
	output logic availNotify,
	output bmsq_pkg::bmsq_tag_t availQueue,
	output bmsq_pkg::bmsq_cnt_t availEntries,
	output logic entryValid,
	output bmsq_pkg::bmsq_entry_t entryData
);
	import bmsq_pkg::*;
	bmsq_entry_t ents [8];
	initial begin
		availNotify = 1'b0;
		availQueue = 16'h0000;
		availEntries = 8'h00;
		entryValid = 1'b0;
		entryData = 80'h0;
	end
	task automatic post(input bmsq_tag_t q, input int n);
		@(negedge sys_clk);
		availNotify = 1'b1;
		availQueue = q;
		availEntries = n[7:0];
		do @(posedge sys_clk); while (clkEn !== 1'b1);
		@(negedge sys_clk);
		availNotify = 1'b0;
		availQueue = ~q;
		for (int i = 0; i < n; i++) begin
			entryValid = 1'b1;
			entryData = ents[i];
			do @(posedge sys_clk); while (entryReady !== 1'b1);
			@(negedge sys_clk);
		end
		entryValid = 1'b0;
		entryData = ~entryData;
	endtask
endmodule // bmsq_guest_model

// ### tb/bmsq_stats_queue_tb.sv
`timescale 1ns/1ps

// --------
// Bench for the statistics queue.
// --------
module bmsq_stats_queue_tb;
	import bmsq_pkg::*;
	logic sys_clk, srst, statsQueueFeature, driverReady, legacyMode, guestBigEndian;
	logic statsRequest, availNotify, entryValid, entryReady, usedNotify, statValid;
	logic channelActive, bufferHeld, requestPending;
	logic statReady = 1'b1;
	logic clkEn = 1'b1;
	logic stallMode = 1'b0;
	localparam int STAT_N = 7;
	bmsq_tag_t supp [7];
	bmsq_tag_t availQueue, statTag, skippedCount;
	bmsq_cnt_t availEntries;
	bmsq_entry_t entryData;
	bmsq_val_t statValue;
	logic [79:0] expQ [$];
	int errTotal, nTests, cycles, expSkip;

	bmsq_stats_queue dut_u (.sys_clk(sys_clk), .srst(srst), .clkEn(clkEn),
		.statsQueueFeature(statsQueueFeature), .driverReady(driverReady),
		.legacyMode(legacyMode), .guestBigEndian(guestBigEndian),
		.statsRequest(statsRequest), .availNotify(availNotify), .availQueue(availQueue),
		.availEntries(availEntries), .entryValid(entryValid), .entryReady(entryReady),
		.entryData(entryData), .usedNotify(usedNotify), .statValid(statValid),
		.statReady(statReady), .statTag(statTag), .statValue(statValue),
		.channelActive(channelActive), .bufferHeld(bufferHeld),
		.requestPending(requestPending), .skippedCount(skippedCount));
	bmsq_guest_model gm (.sys_clk(sys_clk), .clkEn(clkEn), .entryReady(entryReady),
		.availNotify(availNotify), .availQueue(availQueue), .availEntries(availEntries),
		.entryValid(entryValid), .entryData(entryData));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		nTests++;
		if (got !== exp) begin
			errTotal++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic tallyAndFinish();
		$display("checks %0d mismatches %0d", nTests, errTotal);
		if (errTotal == 0 && nTests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	always @(posedge sys_clk) begin
		cycles++;
		if (cycles > 20000) begin
			errTotal++;
			tallyAndFinish();
		end else if (statValid === 1'b1 && statReady === 1'b1 && clkEn === 1'b1) begin
			if (expQ.size() == 0) begin
				nTests++;
				errTotal++;
				$display("unexpected at %0t: got %h expected %h", $time,
					{statTag, statValue}, 80'h0);
			end else begin
				chk({statTag, statValue}, expQ.pop_front());
			end
		end
	end
	always @(negedge sys_clk) statReady <= ($urandom_range(2) == 0);
	always @(negedge sys_clk) clkEn <= !stallMode || ($urandom_range(3) != 0);

	function automatic bmsq_entry_t enc(input bmsq_tag_t t, input bmsq_val_t v, input logic be);
		logic [79:0] big;
		logic [79:0] lit;
		bmsq_entry_t r;
		big = {t, v};
		lit = {v, t};
		for (int k = 0; k < 10; k++) r[8*k+:8] = be ? big[79-8*k-:8] : lit[8*k+:8];
		return r;
	endfunction

	task automatic fill(input logic be, input logic drop);
		bmsq_tag_t t;
		bmsq_val_t v;
		int j;
		for (int i = STAT_N - 1; i > 0; i--) begin
			j = $urandom_range(i);
			t = supp[i];
			supp[i] = supp[j];
			supp[j] = t;
		end
		for (int i = 0; i < STAT_N; i++) begin
			t = drop ? 16'($urandom) : supp[i];
			v = {$urandom, $urandom};
			gm.ents[i] = enc(t, v, be);
			if (!drop && t < 16'h000A) expQ.push_back({t, v});
			else if (!drop) expSkip++;
		end
	endtask

	task automatic settle();
		int k = 0;
		while ((expQ.size() != 0 || bufferHeld !== 1'b1) && k < 300) begin
			@(negedge sys_clk);
			k++;
		end
		chk(80'(bufferHeld), 80'h1);
		chk(80'(expQ.size()), 80'h0);
		chk(80'(skippedCount), 80'(expSkip));
	endtask

	task automatic ask();
		statsRequest = 1'b1;
		do @(posedge sys_clk); while (clkEn !== 1'b1);
		@(negedge sys_clk);
		statsRequest = 1'b0;
	endtask

	task automatic seeUsed(input logic expUsed);
		int k = 0;
		while (usedNotify !== 1'b1 && k < 20) begin
			@(negedge sys_clk);
			k++;
		end
		chk(80'(usedNotify), 80'(expUsed));
		chk(80'(bufferHeld), 80'h0);
	endtask

	task automatic round(input logic be);
		ask();
		seeUsed(1'b1);
		fill(be, 1'b0);
		gm.post(16'h0002, STAT_N);
		settle();
	endtask

	initial begin
		void'($urandom(4512));
		supp = '{16'h0000, 16'h0002, 16'h0003, 16'h0005, 16'h0006, 16'h0009, 16'h000B};
		supp[6] = 16'($urandom_range(16'hFFFF, 16'h000A));
		srst = 1'b1;
		statsQueueFeature = 1'b0;
		driverReady = 1'b1;
		legacyMode = 1'b0;
		guestBigEndian = 1'b0;
		statsRequest = 1'b0;
		repeat (6) @(posedge sys_clk);
		@(negedge sys_clk);
		srst = 1'b0;
		chk(80'({channelActive, bufferHeld, statValid, skippedCount}), 80'h0);
		gm.post(16'h0002, 0);
		chk(80'(channelActive), 80'h0);
		statsQueueFeature = 1'b1;
		gm.post(16'h0003, 0);
		chk(80'(channelActive), 80'h0);
		gm.post(16'h0002, 0);
		settle();
		for (int b = 0; b < 4; b++) round(1'b0);
		ask();
		seeUsed(1'b1);
		ask();
		seeUsed(1'b0);
		chk(80'(requestPending), 80'h1);
		fill(1'b0, 1'b0);
		gm.post(16'h0002, STAT_N);
		seeUsed(1'b1);
		fill(1'b0, 1'b0);
		gm.post(16'h0002, STAT_N);
		settle();
		srst = 1'b1;
		legacyMode = 1'b1;
		guestBigEndian = 1'b1;
		expSkip = 0;
		@(negedge sys_clk);
		srst = 1'b0;
		fill(1'b1, 1'b1);
		gm.post(16'h0002, STAT_N);
		settle();
		round(1'b1);
		guestBigEndian = 1'b0;
		stallMode = 1'b1;
		round(1'b0);
		stallMode = 1'b0;
		tallyAndFinish();
	end
endmodule // bmsq_stats_queue_tb
